// ==== logic/ila_pkg.sv ====
// constants, register map and carrier types of the interrupt level acceptance block
`default_nettype none

package ila_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned PC_W     = 16;
  localparam int unsigned PSW_W    = 8;
  localparam int unsigned LVL_W    = 2;
  localparam int unsigned NUM_LVL  = 4;
  localparam int unsigned NUM_SRC  = 16;
  localparam int unsigned SRC_IW   = 4;
  localparam int unsigned EVT_W    = 3;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_CTRL_ENABLE_REG     = 16'hf020;
  localparam logic [ADDR_W-1:0] ADDR_CIL      = 16'hf022;
  localparam logic [ADDR_W-1:0] ADDR_REQ      = 16'hf024;
  localparam logic [ADDR_W-1:0] ADDR_REQ_BIT  = 16'hf026;
  localparam logic [ADDR_W-1:0] ADDR_IE       = 16'hf028;
  localparam logic [ADDR_W-1:0] ADDR_LVL_LO   = 16'hf02a;
  localparam logic [ADDR_W-1:0] ADDR_LVL_HI   = 16'hf02c;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 16'hf02e;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 16'hf030;
  localparam logic [ADDR_W-1:0] ADDR_CORE     = 16'hf032;

  // ==========================================================================
  // field positions
  localparam int unsigned LEVEL_CTRL_ENABLE_REG_ENABLE_POS = 0;
  localparam int unsigned REQ_BIT_VAL_POS = 8;
  localparam int unsigned PSW_MIE_POS     = 3;
  localparam int unsigned PSW_EL_LSB      = 0;
  localparam int unsigned EL_W            = 2;
  localparam int unsigned EVT_MSK_TAKEN   = 0;
  localparam int unsigned EVT_NMI_TAKEN   = 1;
  localparam int unsigned EVT_DEFERRED    = 2;
  localparam int unsigned CORE_MIE_POS    = 2;
  localparam int unsigned CORE_WIN_LSB    = 4;
  localparam int unsigned CORE_NMI_POS    = 8;

  // ==========================================================================
  // codes and reset values
  localparam logic [EL_W-1:0]    EL_NONE   = 2'h0;
  localparam logic [EL_W-1:0]    EL_ONE    = 2'h1;
  localparam logic [EL_W-1:0]    EL_TWO    = 2'h2;
  localparam logic [PC_W-1:0]    VEC_BASE  = 16'h0010;
  localparam logic [PC_W-1:0]    VEC_NMI   = 16'h0008;
  localparam logic [DATA_W-1:0]  RST_WORD  = 16'h0000;
  localparam logic [NUM_LVL-1:0] RST_CIL   = 4'h0;
  localparam logic [EVT_W-1:0]   RST_EVT   = 3'h0;
  localparam logic [PC_W-1:0]    RST_PC    = 16'h0000;
  localparam logic [PSW_W-1:0]   RST_PSW   = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_OPEN, ST_VECTOR, ST_PREFIX} ila_win_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ila_bus_req_t;

  typedef struct packed {
    logic instr_done;
    logic dsr_prefix;
    logic ei;
    logic di;
    logic rti;
  } ila_cpu_evt_t;

  typedef struct packed {
    logic            take;
    logic            nmi;
    logic [PC_W-1:0] vector;
  } ila_take_t;

endpackage

`default_nettype wire

// ==== logic/ila_arbiter.sv ====
// highest-level pick among eligible maskable requests, lowest index wins a tie
`timescale 1ns/100ps
`default_nettype none

module ila_arbiter #(
  parameter int unsigned N  = 16,
  parameter int unsigned LW = 2,
  parameter int unsigned IW = 4
) (
  input  wire logic [N-1:0]    eligible_i,
  input  wire logic [N*LW-1:0] levels_i,
  output logic                 valid_o,
  output logic [IW-1:0]        index_o,
  output logic [LW-1:0]        level_o
);

  // ==========================================================================
  // linear scan: strict greater-than keeps the earlier index on equal level
  always_comb begin
    valid_o = 1'b0;
    index_o = '0;
    level_o = '0;
    for (int i = 0; i < N; i++) begin
      if (eligible_i[i] && (!valid_o || levels_i[i*LW +: LW] > level_o)) begin
        valid_o = 1'b1;
        index_o = IW'(i);
        level_o = levels_i[i*LW +: LW];
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/ila_core.sv ====
// interrupt level acceptance: request flags, nesting control, disable windows
//
// Operation
// (R1) nmi preempts maskable handler regardless of enables
// (R2) nested maskable accepted only at higher level
// (R3) refuse levels at or below recorded level
// (R4) writing level record clears its highest bit
// (R5) level control only while enable bit set
// (R6) hold requests until first handler instruction completes
// (R7) defer requests until instruction after prefix
// (R8) bit writes clear only the addressed flag
// (R9) maskable entry: level-one save, level one, mie off
// (R10) nmi entry: level-two save, level two
// (R11) enable bit zero: plain master-enable gating
// (R12) accepted maskable sets its level record bit
// (R13) present highest-level request, fixed tie order
`timescale 1ns/100ps
`default_nettype none

module ila_core (
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire ila_pkg::ila_bus_req_t         bus_i,
  output logic [ila_pkg::DATA_W-1:0]         rdata_o,
  input  wire logic [ila_pkg::NUM_SRC-1:0]   irq_src_i,
  input  wire logic                          nmi_i,
  input  wire ila_pkg::ila_cpu_evt_t         cpu_i,
  input  wire logic [ila_pkg::PC_W-1:0]      pc_i,
  input  wire logic [ila_pkg::PSW_W-1:0]     psw_i,
  output ila_pkg::ila_take_t                 take_o,
  output logic                               master_int_enable_flag_o,
  output logic [ila_pkg::EL_W-1:0]           exception_level_field_o,
  output logic [ila_pkg::PC_W-1:0]           level1_link_save_o,
  output logic [ila_pkg::PSW_W-1:0]          level1_status_save_o,
  output logic [ila_pkg::PC_W-1:0]           level2_link_save_o,
  output logic [ila_pkg::PSW_W-1:0]          level2_status_save_o,
  output logic                               irq_o
);
  import ila_pkg::*;

  // ==========================================================================
  // functions
  // highest set bit of the level record: {any, index}
  function automatic logic [LVL_W:0] rec_top(input logic [NUM_LVL-1:0] rec);
    logic [LVL_W:0] r;
    r = '0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (rec[i]) begin
        r = {1'b1, LVL_W'(i)};
      end
    end
    return r;
  endfunction

  // status word as saved: software-visible bits plus this block's mie and level
  function automatic logic [PSW_W-1:0] psw_merge(input logic [PSW_W-1:0] p,
                                                 input logic master_int_enable_flag,
                                                 input logic [EL_W-1:0] el);
    logic [PSW_W-1:0] r;
    r = p;
    r[PSW_MIE_POS] = master_int_enable_flag;
    r[PSW_EL_LSB +: EL_W] = el;
    return r;
  endfunction

  // ==========================================================================
  // state
  logic                  level_ctrl_enable_bit_r;
  logic [NUM_LVL-1:0]    current_level_reg_r;
  logic [NUM_SRC-1:0]    request_flags_reg_a_r;
  logic [NUM_SRC-1:0]    req_enable_r;
  logic [2*DATA_W-1:0]   src_level_r;
  logic [EVT_W-1:0]      evt_stat_r;
  logic [EVT_W-1:0]      evt_mask_r;
  logic                  nmi_pend_r;
  logic                  mie_r;
  logic [EL_W-1:0]       exception_level_field_r;
  ila_win_t              win_r;
  ila_win_t              win_nxt;
  logic [PC_W-1:0]       l1_link_r;
  logic [PSW_W-1:0]      l1_stat_r;
  logic [PC_W-1:0]       l2_link_r;
  logic [PSW_W-1:0]      l2_stat_r;
  logic [DATA_W-1:0]     rdata_r;
  ila_take_t             take_r;

  // ==========================================================================
  // register decode
  wire wr_level_ctrl_enable_reg    = bus_i.wr && (bus_i.addr == ADDR_LEVEL_CTRL_ENABLE_REG);
  wire wr_cil     = bus_i.wr && (bus_i.addr == ADDR_CIL);
  wire wr_req_bit = bus_i.wr && (bus_i.addr == ADDR_REQ_BIT);
  wire wr_ie      = bus_i.wr && (bus_i.addr == ADDR_IE);
  wire wr_lvl_lo  = bus_i.wr && (bus_i.addr == ADDR_LVL_LO);
  wire wr_lvl_hi  = bus_i.wr && (bus_i.addr == ADDR_LVL_HI);
  wire wr_stat    = bus_i.wr && (bus_i.addr == ADDR_EVT_STAT);
  wire wr_mask    = bus_i.wr && (bus_i.addr == ADDR_EVT_MASK);

  wire [SRC_IW-1:0]  bit_idx   = bus_i.wdata[SRC_IW-1:0];
  wire               bit_val   = bus_i.wdata[REQ_BIT_VAL_POS];
  wire [NUM_SRC-1:0] bit_onehot = NUM_SRC'(1) << bit_idx;
  // a single-bit write so software never wipes flags it did not address
  wire [NUM_SRC-1:0] sw_clr = (wr_req_bit && !bit_val) ? bit_onehot : '0; // R8
  wire [NUM_SRC-1:0] sw_set = (wr_req_bit && bit_val) ? bit_onehot : '0;

  // ==========================================================================
  // acceptance
  wire [LVL_W:0]   top      = rec_top(current_level_reg_r);
  wire             rec_any  = top[LVL_W];
  wire [LVL_W-1:0] rec_lvl  = top[LVL_W-1:0];
  wire [NUM_LVL-1:0] top_onehot = NUM_LVL'(1) << rec_lvl;

  logic [NUM_SRC-1:0] lvl_ok;
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      // R5 R11: the record only counts while level control is on
      lvl_ok[i] = !level_ctrl_enable_bit_r || !rec_any ||
                  (src_level_r[i*LVL_W +: LVL_W] > rec_lvl); // R2 R3
    end
  end

  // a maskable handler must not overwrite the level-one save of a running nmi
  wire msk_gate = mie_r && (exception_level_field_r != EL_TWO);
  wire [NUM_SRC-1:0] eligible = request_flags_reg_a_r & req_enable_r & lvl_ok &
                                {NUM_SRC{msk_gate}};

  wire               arb_valid;
  wire [SRC_IW-1:0]  arb_index;
  wire [LVL_W-1:0]   arb_level;

  ila_arbiter #(
    .N  (NUM_SRC),
    .LW (LVL_W),
    .IW (SRC_IW)
  ) u_arbiter (
    .eligible_i (eligible),
    .levels_i   (src_level_r),
    .valid_o    (arb_valid), // R13
    .index_o    (arb_index),
    .level_o    (arb_level)
  );

  // takes land only on instruction boundaries; the boundary of a prefix is
  // skipped, and after a take nothing is taken until the first handler
  // instruction has finished
  wire boundary  = cpu_i.instr_done && !cpu_i.dsr_prefix && !take_r.take; // R6 R7
  wire nmi_ok    = nmi_pend_r && (exception_level_field_r != EL_TWO);
  wire take_nmi  = boundary && nmi_ok; // R1
  wire take_msk  = boundary && !nmi_ok && arb_valid;
  wire deferred  = (nmi_ok || arb_valid) && cpu_i.instr_done && !boundary;

  wire [NUM_SRC-1:0] ack_clr = take_msk ? (NUM_SRC'(1) << arb_index) : '0;
  wire [NUM_LVL-1:0] rec_set = (take_msk && level_ctrl_enable_bit_r) ?
                               (NUM_LVL'(1) << arb_level) : '0; // R12
  // any write to the record drops its top bit; a same-cycle take still lands
  wire [NUM_LVL-1:0] rec_clr = (wr_cil && rec_any) ? top_onehot : '0; // R4

  wire [EVT_W-1:0] evt_set = {deferred, take_nmi, take_msk};
  wire [EVT_W-1:0] evt_clr = wr_stat ? bus_i.wdata[EVT_W-1:0] : '0;

  wire [PSW_W-1:0] psw_save = psw_merge(psw_i, mie_r, exception_level_field_r);
  wire [PSW_W-1:0] ret_psw  = (exception_level_field_r == EL_TWO) ? l2_stat_r : l1_stat_r;

  // ==========================================================================
  // disable window tracking
  always_comb begin
    win_nxt = win_r;
    case (win_r)
      ST_OPEN: begin
        if (take_nmi || take_msk) begin
          win_nxt = ST_VECTOR; // R6
        end else if (cpu_i.instr_done && cpu_i.dsr_prefix) begin
          win_nxt = ST_PREFIX; // R7
        end
      end
      ST_VECTOR, ST_PREFIX: begin
        if (cpu_i.instr_done && !cpu_i.dsr_prefix) begin
          win_nxt = ST_OPEN;
        end
      end
      default: win_nxt = ST_OPEN;
    endcase
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_ctrl_enable_bit_r <= 1'b0;
      req_enable_r            <= RST_WORD;
      src_level_r             <= {RST_WORD, RST_WORD};
      evt_mask_r              <= RST_EVT;
    end else begin
      if (wr_level_ctrl_enable_reg) begin
        level_ctrl_enable_bit_r <= bus_i.wdata[LEVEL_CTRL_ENABLE_REG_ENABLE_POS]; // R5 R11
      end
      if (wr_ie) begin
        req_enable_r <= bus_i.wdata;
      end
      if (wr_lvl_lo) begin
        src_level_r[DATA_W-1:0] <= bus_i.wdata;
      end
      if (wr_lvl_hi) begin
        src_level_r[2*DATA_W-1:DATA_W] <= bus_i.wdata;
      end
      if (wr_mask) begin
        evt_mask_r <= bus_i.wdata[EVT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // flags: a set in the clearing cycle always survives
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      request_flags_reg_a_r <= RST_WORD;
      current_level_reg_r   <= RST_CIL;
      evt_stat_r            <= RST_EVT;
      nmi_pend_r            <= 1'b0;
    end else begin
      request_flags_reg_a_r <= (request_flags_reg_a_r & ~sw_clr & ~ack_clr) |
                               irq_src_i | sw_set; // R8
      current_level_reg_r   <= (current_level_reg_r & ~rec_clr) | rec_set; // R4 R12
      evt_stat_r            <= (evt_stat_r & ~evt_clr) | evt_set;
      nmi_pend_r            <= (nmi_pend_r && !take_nmi) || nmi_i;
    end
  end

  // ==========================================================================
  // entry, return and enable control
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mie_r     <= 1'b0;
      exception_level_field_r  <= EL_NONE;
      win_r     <= ST_OPEN;
      l1_link_r <= RST_PC;
      l1_stat_r <= RST_PSW;
      l2_link_r <= RST_PC;
      l2_stat_r <= RST_PSW;
    end else begin
      win_r <= win_nxt;
      if (take_nmi) begin
        l2_link_r <= pc_i; // R10
        l2_stat_r <= psw_save; // R10
        exception_level_field_r  <= EL_TWO; // R10
      end else if (take_msk) begin
        l1_link_r <= pc_i; // R9
        l1_stat_r <= psw_save; // R9
        exception_level_field_r  <= EL_ONE; // R9
        mie_r     <= 1'b0; // R9
      end else if (cpu_i.rti) begin
        exception_level_field_r <= ret_psw[PSW_EL_LSB +: EL_W];
        mie_r    <= ret_psw[PSW_MIE_POS];
      end else if (cpu_i.ei) begin
        mie_r <= 1'b1;
      end else if (cpu_i.di) begin
        mie_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // take output to the core
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      take_r <= '0;
    end else begin
      take_r.take   <= take_nmi || take_msk;
      take_r.nmi    <= take_nmi;
      take_r.vector <= take_nmi ? VEC_NMI :
                       PC_W'(VEC_BASE + (PC_W'(arb_index) << 1));
    end
  end

  // ==========================================================================
  // read port: data only in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (bus_i.addr)
      ADDR_LEVEL_CTRL_ENABLE_REG:     rd_mux[LEVEL_CTRL_ENABLE_REG_ENABLE_POS] = level_ctrl_enable_bit_r;
      ADDR_CIL:      rd_mux[NUM_LVL-1:0] = current_level_reg_r;
      ADDR_REQ:      rd_mux = request_flags_reg_a_r;
      ADDR_IE:       rd_mux = req_enable_r;
      ADDR_LVL_LO:   rd_mux = src_level_r[DATA_W-1:0];
      ADDR_LVL_HI:   rd_mux = src_level_r[2*DATA_W-1:DATA_W];
      ADDR_EVT_STAT: rd_mux[EVT_W-1:0] = evt_stat_r;
      ADDR_EVT_MASK: rd_mux[EVT_W-1:0] = evt_mask_r;
      ADDR_CORE: begin
        rd_mux[EL_W-1:0]             = exception_level_field_r;
        rd_mux[CORE_MIE_POS]         = mie_r;
        rd_mux[CORE_WIN_LSB +: 2]    = win_r;
        rd_mux[CORE_NMI_POS]         = nmi_pend_r;
      end
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= RST_WORD;
    end else begin
      rdata_r <= bus_i.rd ? rd_mux : RST_WORD;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o                  = rdata_r;
  assign take_o                   = take_r;
  assign master_int_enable_flag_o = mie_r;
  assign exception_level_field_o  = exception_level_field_r;
  assign level1_link_save_o       = l1_link_r;
  assign level1_status_save_o     = l1_stat_r;
  assign level2_link_save_o       = l2_link_r;
  assign level2_status_save_o     = l2_stat_r;
  assign irq_o                    = |(evt_stat_r & evt_mask_r);

endmodule

`default_nettype wire

// ==== verification/ila_checker.sv ====
// concurrent checks on the ports of the acceptance block
`timescale 1ns/100ps
`default_nettype none

module ila_checker
  import ila_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         reset_n_i,
  input wire ila_pkg::ila_bus_req_t        bus_i,
  input wire logic [ila_pkg::DATA_W-1:0]   rdata_o,
  input wire logic [ila_pkg::NUM_SRC-1:0]  irq_src_i,
  input wire logic                         nmi_i,
  input wire ila_pkg::ila_cpu_evt_t        cpu_i,
  input wire logic [ila_pkg::PC_W-1:0]     pc_i,
  input wire logic [ila_pkg::PSW_W-1:0]    psw_i,
  input wire ila_pkg::ila_take_t           take_o,
  input wire logic                         master_int_enable_flag_o,
  input wire logic [ila_pkg::EL_W-1:0]     exception_level_field_o,
  input wire logic [ila_pkg::PC_W-1:0]     level1_link_save_o,
  input wire logic [ila_pkg::PSW_W-1:0]    level1_status_save_o,
  input wire logic [ila_pkg::PC_W-1:0]     level2_link_save_o,
  input wire logic [ila_pkg::PSW_W-1:0]    level2_status_save_o,
  input wire logic                         irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ==========================================================================
  // take timing
  take_pulse_a: assert property (take_o.take |=> !take_o.take)
    else $error("take held longer than one cycle");
  prefix_defer_a: assert property (cpu_i.instr_done && cpu_i.dsr_prefix |=> !take_o.take)
    else $error("take right after a prefix code");
  take_cause_a: assert property (take_o.take |-> $past(cpu_i.instr_done) && !$past(cpu_i.dsr_prefix))
    else $error("take without a plain instruction boundary");

  // ==========================================================================
  // entry side effects
  msk_entry_a: assert property (take_o.take && !take_o.nmi |-> exception_level_field_o == EL_ONE
    && !master_int_enable_flag_o && level1_link_save_o == $past(pc_i))
    else $error("maskable entry state wrong");
  msk_status_a: assert property (take_o.take && !take_o.nmi |-> level1_status_save_o ==
    (($past(psw_i) & 8'hf4) | {4'h0, $past(master_int_enable_flag_o), 1'b0, $past(exception_level_field_o)}))
    else $error("maskable status copy wrong");
  nmi_entry_a: assert property (take_o.take && take_o.nmi |-> exception_level_field_o == EL_TWO
    && take_o.vector == VEC_NMI && level2_link_save_o == $past(pc_i))
    else $error("nmi entry state wrong");
  nmi_status_a: assert property (take_o.take && take_o.nmi |-> level2_status_save_o ==
    (($past(psw_i) & 8'hf4) | {4'h0, $past(master_int_enable_flag_o), 1'b0, $past(exception_level_field_o)}))
    else $error("nmi status copy wrong");
  msk_gate_a: assert property (take_o.take && !take_o.nmi |-> $past(master_int_enable_flag_o)
    && $past(exception_level_field_o) != EL_TWO)
    else $error("maskable taken while gated");
  msk_vector_a: assert property (take_o.take && !take_o.nmi |-> !take_o.vector[0]
    && (take_o.vector - VEC_BASE) < 16'h0020)
    else $error("maskable vector out of table");

  // ==========================================================================
  // interrupt line and read port
  irq_cause_a: assert property ($changed(irq_o) |-> take_o.take || $past(bus_i.wr)
    || $past(cpu_i.instr_done))
    else $error("interrupt line moved without cause");
  rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside its cycle");
endmodule

`default_nettype wire

// ==== verification/ila_cpu_model.sv ====
// behavioural core: instruction boundaries, status word and handler entry
`timescale 1ns/100ps
`default_nettype none

module ila_cpu_model (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [2:0]            cmd_i,
  input  wire ila_pkg::ila_take_t    take_i,
  output ila_pkg::ila_cpu_evt_t      cpu_o,
  output logic [ila_pkg::PC_W-1:0]   pc_o,
  output logic [ila_pkg::PSW_W-1:0]  psw_o
);
  import ila_pkg::*;
  // commands: 1 instruction, 2 prefix code, 3 enable, 4 disable, 5 return
  logic instr_w;
  assign instr_w = (cmd_i == 3'h1) || (cmd_i == 3'h2);
  assign cpu_o = '{instr_done: instr_w, dsr_prefix: (cmd_i == 3'h2), ei: (cmd_i == 3'h3),
                   di: (cmd_i == 3'h4), rti: (cmd_i == 3'h5)};
  // pc walks so every saved copy differs from the last one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_o <= 16'h0100;
    end else if (take_i.take) begin
      pc_o <= take_i.vector;
    end else if (instr_w) begin
      pc_o <= pc_o + 16'h0002;
    end
  end
  assign psw_o = pc_o[8:1];
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the acceptance block against the core model
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ila_pkg::*;
  logic               clk_i = 1'b0;
  logic               reset_n_i = 1'b0;
  ila_bus_req_t       bus = '0;
  logic [NUM_SRC-1:0] src = '0;
  logic               nmi = 1'b0;
  logic [2:0]         cmd = 3'h0;
  logic [DATA_W-1:0]  rdata;
  ila_take_t          take;
  ila_cpu_evt_t       cpu;
  logic [PC_W-1:0]    pc, p, pp, l1_link, l2_link;
  logic [PSW_W-1:0]   psw, q, qp, l1_st, l2_st;
  logic [EL_W-1:0]    lvl;
  logic               master_int_enable_flag, irq;
  int                 fail_count = 0;
  int                 total_checks = 0;

  always #10 clk_i = ~clk_i;

  ila_core ila_core_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rdata_o(rdata),
    .irq_src_i(src), .nmi_i(nmi), .cpu_i(cpu), .pc_i(pc), .psw_i(psw), .take_o(take),
    .master_int_enable_flag_o(master_int_enable_flag), .exception_level_field_o(lvl),
    .level1_link_save_o(l1_link), .level1_status_save_o(l1_st),
    .level2_link_save_o(l2_link), .level2_status_save_o(l2_st), .irq_o(irq));
  ila_cpu_model ila_cpu_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
    .take_i(take), .cpu_o(cpu), .pc_o(pc), .psw_o(psw));

  // ==========================================================================
  // access tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus <= '0;
    #1;
  endtask

  task automatic rdc(input string nm, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    bus <= '0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // sets the core command and request lines for the next edge; pp/qp hold what the edge it waited on saw
  task automatic tick(input logic [2:0] c, input logic n, input logic [15:0] s);
    @(posedge clk_i);
    cmd <= c;
    nmi <= n;
    src <= s;
    #1;
    pp = p;
    qp = q;
    p = pc;
    q = psw;
  endtask

  task automatic step_take(input logic t, input logic [15:0] vec);
    tick(3'h1, 1'b0, 16'h0000);
    tick(3'h0, 1'b0, 16'h0000);
    chk("take", 16'(take.take), 16'(t));
    if (t) chk("vector", take.vector, vec);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 5000);
    fail_count++;
    final_report();
  end

  // ==========================================================================
  // tests
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rdc("reset value", (i < 10) ? ADDR_LEVEL_CTRL_ENABLE_REG + 16'(2 * i) : 16'hf0fe, 16'h0000);
    end
    chk("irq reset", 16'(irq), 16'h0000);
    $display("test reset done");

    wr(ADDR_IE, 16'h00ac);
    wr(ADDR_LVL_LO, 16'h8870);
    wr(ADDR_LEVEL_CTRL_ENABLE_REG, 16'h0001);
    tick(3'h3, 1'b0, 16'h00a8);
    step_take(1'b1, 16'h001a);
    chk("level", 16'(lvl), 16'h0001);
    chk("mie", 16'(master_int_enable_flag), 16'h0000);
    chk("l1 link", l1_link, pp);
    chk("l1 status", 16'(l1_st), 16'((qp & 8'hf4) | 8'h08));
    rdc("record", ADDR_CIL, 16'h0004);
    rdc("flags", ADDR_REQ, 16'h0088);
    tick(3'h3, 1'b0, 16'h0000);
    step_take(1'b0, 16'h0000);
    tick(3'h0, 1'b0, 16'h0004);
    step_take(1'b1, 16'h0014);
    rdc("record", ADDR_CIL, 16'h000c);
    wr(ADDR_CIL, 16'h0000);
    rdc("record", ADDR_CIL, 16'h0004);
    wr(ADDR_CIL, 16'h0000);
    rdc("record", ADDR_CIL, 16'h0000);
    tick(3'h3, 1'b0, 16'h0000);
    step_take(1'b1, 16'h001e);
    $display("test level nesting done");

    wr(ADDR_LEVEL_CTRL_ENABLE_REG, 16'h0000);
    tick(3'h3, 1'b0, 16'h0000);
    step_take(1'b1, 16'h0016);
    rdc("flags", ADDR_REQ, 16'h0000);
    $display("test control off done");

    rdc("event status", ADDR_EVT_STAT, 16'h0001);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(ADDR_EVT_MASK, 16'h0007);
    chk("irq unmasked", 16'(irq), 16'h0001);
    wr(ADDR_EVT_STAT, 16'h0001);
    chk("irq cleared", 16'(irq), 16'h0000);
    rdc("event status", ADDR_EVT_STAT, 16'h0000);
    tick(3'h3, 1'b0, 16'h0000);
    tick(3'h4, 1'b0, 16'h0000);
    chk("mie after ei", 16'(master_int_enable_flag), 16'h0001);
    tick(3'h0, 1'b0, 16'h0000);
    chk("mie after di", 16'(master_int_enable_flag), 16'h0000);
    $display("test event interrupt done");

    tick(3'h3, 1'b0, 16'h0008);
    tick(3'h1, 1'b1, 16'h0000);
    tick(3'h1, 1'b0, 16'h0000);
    chk("maskable take", 16'({take.take, take.nmi}), 16'h0002);
    tick(3'h1, 1'b0, 16'h0000);
    chk("first handler instr", 16'(take.take), 16'h0000);
    tick(3'h0, 1'b0, 16'h0000);
    chk("nmi take", 16'({take.take, take.nmi}), 16'h0003);
    chk("mie kept", 16'(master_int_enable_flag), 16'h0000);
    chk("nmi vector", take.vector, VEC_NMI);
    chk("level", 16'(lvl), 16'h0002);
    chk("l2 link", l2_link, pp);
    chk("l2 status", 16'(l2_st), 16'((qp & 8'hf4) | 8'h01));
    rdc("event status", ADDR_EVT_STAT, 16'h0007);
    wr(ADDR_EVT_STAT, 16'h0007);
    $display("test entry window done");

    tick(3'h5, 1'b0, 16'h0000);
    tick(3'h0, 1'b1, 16'h0000);
    tick(3'h2, 1'b0, 16'h0000);
    tick(3'h1, 1'b0, 16'h0000);
    chk("at prefix", 16'(take.take), 16'h0000);
    tick(3'h0, 1'b0, 16'h0000);
    chk("after prefix", 16'({take.take, take.nmi}), 16'h0003);
    rdc("event status", ADDR_EVT_STAT, 16'h0006);
    $display("test prefix done");

    wr(ADDR_REQ_BIT, 16'h0104);
    wr(ADDR_REQ_BIT, 16'h0103);
    wr(ADDR_REQ_BIT, 16'h0003);
    rdc("flags", ADDR_REQ, 16'h0010);
    rdc("core state", ADDR_CORE, 16'h0002);
    $display("test bit write done");
    final_report();
  end
endmodule

bind ila_core ila_checker ila_checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .irq_src_i(irq_src_i), .nmi_i(nmi_i), .cpu_i(cpu_i), .pc_i(pc_i),
  .psw_i(psw_i), .take_o(take_o), .master_int_enable_flag_o(master_int_enable_flag_o),
  .exception_level_field_o(exception_level_field_o), .level1_link_save_o(level1_link_save_o),
  .level1_status_save_o(level1_status_save_o), .level2_link_save_o(level2_link_save_o),
  .level2_status_save_o(level2_status_save_o), .irq_o(irq_o));

`default_nettype wire
